/* File: eqs_sched.sv */
// egress queue weighted scheduler with its ahb-lite register slave
// Contract
// - queue 2 strict when clear, weighted when set
// - queue 2 allowance field, resets to four
// - queue 1 strict when clear, weighted when set
// - queue 1 allowance field, resets to two
// - queue 0 strict when clear, weighted when set
// - queue 0 allowance field, resets to one
// - rate basis bit, one is port based
// - split selects four, two or one queue
// - queue 3 enable and allowance, reset eight
`timescale 1ns/10ps
`default_nettype none
`include "eqs_params.svh"
module eqs_sched (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  q_pending,
  input  wire logic        tx_ready,
  output logic             tx_grant,
  output logic [1:0]       tx_queue,
  output logic             rl_port_based,
  output logic [1:0]       split_mode
);
  // ****************************************
  // register slave
  // ****************************************
  logic [7:0] q_ctl [4];
  logic       wr_pend;
  logic [9:0] wr_idx;
  logic [3:0] cnt_full;
  logic [1:0] last_q;

  wire        acc      = hsel & hready & htrans[1];
  wire        mapped   = (haddr[31:12] == 20'h00000) &
                         (haddr[1:0] == 2'h0) & (hsize == `EQS_HSIZE_WORD);
  wire [9:0]  a_idx    = haddr[11:2];
  wire        rd_req   = acc & ~hwrite & mapped;
  wire        wr_req   = acc & hwrite & mapped;

  function automatic logic hit(input logic [9:0] idx);
    hit = wr_pend & (wr_idx == idx);
  endfunction

  wire [7:0] next_q3    = hit(`EQS_IDX_Q3) ? hwdata[7:0] : q_ctl[3];
  wire [7:0] next_q2    = hit(`EQS_IDX_Q2) ? hwdata[7:0] : q_ctl[2];
  wire [7:0] next_q1    = hit(`EQS_IDX_Q1) ? hwdata[7:0] : q_ctl[1];
  wire [7:0] next_q0    = hit(`EQS_IDX_Q0) ? hwdata[7:0] : q_ctl[0];
  wire [1:0] next_split = hit(`EQS_IDX_SPLIT) ? hwdata[1:0] : split_mode;
  wire       next_rate  = hit(`EQS_IDX_RATE) ?
                          hwdata[`EQS_RATE_PORT_BIT] : rl_port_based;
  wire [7:0] rd_val =
    (a_idx == `EQS_IDX_Q3)     ? next_q3 :
    (a_idx == `EQS_IDX_Q2)     ? next_q2 :
    (a_idx == `EQS_IDX_Q1)     ? next_q1 :
    (a_idx == `EQS_IDX_Q0)     ? next_q0 :
    (a_idx == `EQS_IDX_SPLIT)  ? {6'h00, next_split} :
    (a_idx == `EQS_IDX_RATE)   ? {1'b0, next_rate, 6'h00} :
    (a_idx == `EQS_IDX_STATUS) ? {2'h0, last_q, cnt_full} : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      wr_idx    <= 10'h000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= rd_req ? {24'h000000, rd_val} : 32'h00000000;
      wr_pend   <= wr_req;
      wr_idx    <= a_idx;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ctl[3]      <= `EQS_Q3_RST;
      q_ctl[2]      <= `EQS_Q2_RST;
      q_ctl[1]      <= `EQS_Q1_RST;
      q_ctl[0]      <= `EQS_Q0_RST;
      split_mode    <= `EQS_SPLIT_RST;
      rl_port_based <= `EQS_RATE_RST;
    end else begin
      q_ctl[3]      <= next_q3;
      q_ctl[2]      <= next_q2;
      q_ctl[1]      <= next_q1;
      q_ctl[0]      <= next_q0;
      split_mode    <= next_split;
      rl_port_based <= next_rate;
    end
  end

  // ****************************************
  // scheduler
  // ****************************************
  logic [6:0] cnt [4];

  // queues in use for the split mode, reserved acts as single
  wire [3:0] active =
    (split_mode == eqs_pkg::EQS_SPLIT_FOUR) ? 4'hF :
    (split_mode == eqs_pkg::EQS_SPLIT_TWO)  ? 4'h3 : 4'h1;

  function automatic logic spent(input logic [7:0] ctl,
                                 input logic [6:0] c);
    spent = ctl[`EQS_RATIO_EN_BIT] & (c >= ctl[6:0]);
  endfunction

  wire [3:0] exhausted = {spent(q_ctl[3], cnt[3]), spent(q_ctl[2], cnt[2]),
                          spent(q_ctl[1], cnt[1]), spent(q_ctl[0], cnt[0])};
  // strict queues are never spent, so each active one drains fully before any lower-numbered queue
  wire [3:0] elig    = active & q_pending & ~exhausted;
  wire       any_el  = |elig;
  wire [1:0] pick    = elig[3] ? 2'd3 : elig[2] ? 2'd2 :
                       elig[1] ? 2'd1 : 2'd0;
  wire       next_grant = tx_ready & any_el & ~tx_grant;
  wire       any_cnt = |{cnt[3], cnt[2], cnt[1], cnt[0]};
  wire       refill  = ~any_el & any_cnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_grant <= 1'b0;
      tx_queue <= 2'd0;
      last_q   <= 2'd0;
      cnt_full <= 4'h0;
    end else begin
      tx_grant <= next_grant;
      tx_queue <= next_grant ? pick : tx_queue;
      last_q   <= next_grant ? pick : last_q;
      cnt_full <= exhausted & active;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_cnt
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt[i] <= 7'h00;
      end else if (refill) begin
        cnt[i] <= 7'h00;
      end else if (next_grant && pick == i &&
                   q_ctl[i][`EQS_RATIO_EN_BIT] && cnt[i] != 7'h7F) begin
        cnt[i] <= cnt[i] + 7'h01;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic first_cyc;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  sequence s_wr_rate;
    (hsel && hready && htrans[1] && hwrite && mapped &&
     a_idx == `EQS_IDX_RATE) ##1 1'b1;
  endsequence

  a_q2_reset: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    first_cyc |-> q_ctl[2] == 8'h84)
    else $error("queue 2 control reset wrong");
  a_q1_reset: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    first_cyc |-> q_ctl[1] == 8'h82)
    else $error("queue 1 control reset wrong");
  a_q0_reset: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    first_cyc |-> q_ctl[0] == 8'h81)
    else $error("queue 0 control reset wrong");
  a_q3_reset: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    first_cyc |-> q_ctl[3] == 8'h88)
    else $error("queue 3 control reset wrong");
  a_q2_strict_first: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_grant && tx_queue < 2'd2 |->
      $past(!q_pending[2] || !active[2] || exhausted[2]))
    else $error("lower queue served while queue 2 eligible");
  a_q1_strict_first: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_grant && tx_queue == 2'd0 |->
      $past(!q_pending[1] || !active[1] || exhausted[1]))
    else $error("queue 0 served while queue 1 eligible");
  a_q0_allow_cap: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_grant && tx_queue == 2'd0 && $past(q_ctl[0][7]) |->
      $past(cnt[0] < q_ctl[0][6:0]))
    else $error("queue 0 sent beyond its allowance");
  a_rate_basis_wr: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    s_wr_rate |=> rl_port_based == $past(hwdata[6]))
    else $error("rate basis bit not written");
  a_split_queues: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_grant |-> tx_queue == 2'h0 ||
      $past(split_mode) == eqs_pkg::EQS_SPLIT_FOUR ||
      (tx_queue == 2'h1 && $past(split_mode) == eqs_pkg::EQS_SPLIT_TWO))
    else $error("grant to a queue unused by split mode");
  a_count_restart: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    refill |=> !any_cnt)
    else $error("counts did not restart");
  a_grant_spacing: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    tx_grant |=> !tx_grant)
    else $error("back to back grants");
endmodule
`default_nettype wire

/* File: eqs_params.svh */
// constants of the egress queue weighted scheduler
`ifndef EQS_PARAMS_SVH
`define EQS_PARAMS_SVH
// register indices, byte address is four times the index
`define EQS_IDX_SPLIT    10'h0B1
`define EQS_IDX_Q3       10'h0B2
`define EQS_IDX_Q2       10'h0B3
`define EQS_IDX_Q1       10'h0B4
`define EQS_IDX_Q0       10'h0B5
`define EQS_IDX_RATE     10'h0C6
`define EQS_IDX_STATUS   10'h0C7
// field positions
`define EQS_RATIO_EN_BIT 7
`define EQS_RATE_PORT_BIT 6
// reset values
`define EQS_Q3_RST       8'h88
`define EQS_Q2_RST       8'h84
`define EQS_Q1_RST       8'h82
`define EQS_Q0_RST       8'h81
`define EQS_SPLIT_RST    2'h0
`define EQS_RATE_RST     1'b0
// bus codes
`define EQS_HSIZE_WORD   3'h2
`endif

/* File: eqs_pkg.sv */
// types of the egress queue weighted scheduler
`default_nettype none
package eqs_pkg;
  typedef enum logic [1:0] {
    EQS_SPLIT_ONE  = 2'b00,
    EQS_SPLIT_TWO  = 2'b01,
    EQS_SPLIT_FOUR = 2'b10,
    EQS_SPLIT_RSVD = 2'b11
  } eqs_split_t;
endpackage
`default_nettype wire

/* File: eqs_mac_model.sv */
// partner model: packet queues and transmit mac behind the scheduler
`timescale 1ns/10ps
`default_nettype none
module eqs_mac_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        tx_grant,
  input  wire logic [1:0]  tx_queue,
  input  wire logic        slow,
  input  wire logic        load,
  input  wire logic [15:0] fill,
  output var  logic [3:0]  q_pending,
  output var  logic        tx_ready
);
  // ****************
  // queues and mac
  // ****************
  int depth [4] = '{0, 0, 0, 0};
  always_comb
    for (int i = 0; i < 4; i++) q_pending[i] = depth[i] > 0;
  // mac stalls at random when slow
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) tx_ready <= 1'b0;
    else tx_ready <= !slow || $urandom_range(0, 1);
  // load sets every depth, otherwise one grant takes one packet
  always @(posedge core_clk)
    if (load)
      for (int i = 0; i < 4; i++) depth[i] <= {28'h0, fill[4*i +: 4]};
    else if (tx_grant && depth[tx_queue] > 0)
      depth[tx_queue] <= depth[tx_queue] - 1;
endmodule
`default_nettype wire

/* File: eqs_sched_tb_top.sv */
// self-checking bench for the egress queue scheduler
`timescale 1ns/10ps
`default_nettype none
`include "eqs_params.svh"
module eqs_sched_tb_top;
  logic        core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, tx_queue, split_mode, sp;
  logic [2:0]  hsize = 0;
  logic        hreadyout, hresp, tx_grant, tx_ready, rl_port_based;
  logic [3:0]  q_pending;
  logic        load = 0;
  logic [15:0] fill = 0;
  logic [7:0]  ctl [4];
  logic [7:0]  rst_v [4] = '{`EQS_Q0_RST, `EQS_Q1_RST, `EQS_Q2_RST,
                             `EQS_Q3_RST};
  logic [1:0]  log_q [$], exp_q [$];
  int          errors = 0, n_tests = 0, cyc = 0, pend [4];
  eqs_sched uut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .q_pending,
    .tx_ready, .tx_grant, .tx_queue, .rl_port_based, .split_mode);
  eqs_mac_model mdl (.core_clk, .rst_n, .tx_grant, .tx_queue, .slow, .load,
    .fill, .q_pending, .tx_ready);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (tx_grant === 1'b1) log_q.push_back(tx_queue);
    if (cyc == 30000) begin
      errors++;
      print_verdict();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [9:0] idx, logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= `EQS_HSIZE_WORD;
    haddr <= {20'h0, idx, 2'b00};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
    hsel <= 1'b0;
  endtask
  // load every queue depth of the partner at one edge
  task automatic fill_q(logic [15:0] f);
    fill <= f;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
  endtask
  // spent flags left once every active queue is drained and counts restarted
  function automatic logic [3:0] exp_spent(logic [1:0] s);
    int nq;
    nq = (s == 2'b10) ? 4 : (s == 2'b01) ? 2 : 1;
    exp_spent = 4'h0;
    for (int i = 0; i < nq; i++)
      exp_spent[i] = ctl[i][7] && ctl[i][6:0] == 7'h00;
  endfunction
  // grant order from allowances, enables and split
  function automatic void predict(int p[4], logic [1:0] s);
    int cnt [4];
    int w;
    int nq;
    nq = (s == 2'b10) ? 4 : (s == 2'b01) ? 2 : 1;
    cnt = '{0, 0, 0, 0};
    exp_q.delete();
    for (int n = 0; n < 200; n++) begin
      w = -1;
      for (int i = 0; i < nq; i++)
        if (p[i] > 0 && (!ctl[i][7] || cnt[i] < ctl[i][6:0])) w = i;
      if (w < 0 && cnt.sum() == 0) break;
      if (w < 0) cnt = '{0, 0, 0, 0};
      else begin
        exp_q.push_back(w[1:0]);
        p[w]--;
        if (ctl[w][7]) cnt[w]++;
      end
    end
  endfunction
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'haa7f));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(0, `EQS_IDX_Q0 - 10'(i), 32'h0);
      check("ctl reset", rd,
            {24'h0, rst_v[i]});
    end
    bus(0, `EQS_IDX_SPLIT, 32'h0);
    check("split reset", rd, 32'h0);
    bus(1, 10'h0A0, 32'hFF);
    bus(0, 10'h0A0, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int v = 0; v < 2; v++) begin
      bus(0, `EQS_IDX_RATE, 32'h0);
      check("rate", rd, 32'(v * 8'h40));
      bus(1, `EQS_IDX_RATE, v ? 32'h0 : 32'hFFFF_FFFF);
      bus(0, `EQS_IDX_RATE, 32'h0);
      check("rate pin", {31'h0, rl_port_based}, 32'(1 - v));
    end
    for (int k = 0; k < 10; k++) begin
      sp = k[1:0] ^ 2'b10;
      fill_q(16'h0000);
      foreach (ctl[i]) begin
        ctl[i] = (k == 0) ? rst_v[i]
          : {k != 1 && $urandom_range(0, 1), 7'($urandom_range(0, 5))};
        bus(1, `EQS_IDX_Q0 - 10'(i), {24'($urandom), ctl[i]});
        bus(0, `EQS_IDX_Q0 - 10'(i), 32'h0);
        check("ctl", rd,
              {24'h0, ctl[i]});
        pend[i] = (k == 0) ? 12 : $urandom_range(0, 9);
      end
      bus(1, `EQS_IDX_SPLIT, {30'h0, sp});
      bus(0, `EQS_IDX_SPLIT, 32'h0);
      check("split", rd, {30'h0, sp});
      check("split pin", {30'h0, split_mode}, {30'h0, sp});
      predict(pend, sp);
      log_q.delete();
      slow <= k[0];
      fill_q({4'(pend[3]), 4'(pend[2]), 4'(pend[1]), 4'(pend[0])});
      repeat (1000) if (log_q.size() < exp_q.size()) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      check("grants", log_q.size(), exp_q.size());
      if (log_q.size() == exp_q.size())
        foreach (exp_q[j])
          check("queue", log_q[j], exp_q[j]);
      bus(0, `EQS_IDX_STATUS, 32'h0);
      check("spent", {28'h0, rd[3:0]}, {28'h0, exp_spent(sp)});
      if (exp_q.size() > 0)
        check("last queue", {30'h0, rd[5:4]}, {30'h0, exp_q[$]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
